// [rtl/acb_defines.vh]
// Offsets, fields, reset values and timing counts of the converter back end
`ifndef ACB_DEFINES_VH
`define ACB_DEFINES_VH
`define ACB_OFF_CTRL 8'h00
`define ACB_OFF_STAT 8'h04
`define ACB_OFF_OUTMODE 8'h08
`define ACB_OFF_IRQ 8'h0C
`define ACB_OFF_MASK 8'h10
`define ACB_CTRL_RST 32'h0000_0000
`define ACB_DIV_LSB 0
`define ACB_DIV_MSB 2
`define ACB_DCS_BIT 3
`define ACB_PWR_LSB 4
`define ACB_PWR_MSB 5
`define ACB_FMT_LSB 6
`define ACB_FMT_MSB 7
`define ACB_ILV_BIT 8
`define ACB_OEB_LSB 5
`define ACB_OEB_MSB 6
`define ACB_PWR_NORMAL 2'h0
`define ACB_PWR_DOWN 2'h1
`define ACB_PWR_STANDBY 2'h2
`define ACB_FMT_OFFBIN 2'h0
`define ACB_FMT_TWOS 2'h1
`define ACB_FMT_GRAY 2'h2
`define ACB_MODE_OFF 2'h0
`define ACB_MODE_OEB 2'h1
`define ACB_MODE_POWER_DOWN_PIN 2'h2
`define ACB_MODE_STBY 2'h3
`define ACB_IRQ_OVR 0
`define ACB_IRQ_LOCK 1
`define ACB_IRQ_PWR 2
`define ACB_LATENCY 8
`define ACB_CLK_NS 10
`define ACB_CLK_HZ 100000000
`define ACB_DCS_MIN_HZ 20000000
`define ACB_LOCK_NS 1500
`define ACB_LOCK_CYC ((`ACB_LOCK_NS + `ACB_CLK_NS - 1) / `ACB_CLK_NS)
`endif

// [rtl/acb_backend.v]
// Clock divider, duty cycle stabilizer, power modes and output back end
`timescale 1ns/1ns
`include "acb_defines.vh"
module acb_backend #(
	parameter DW = 16,
	parameter AW = 18,
	parameter LOCK_CYC = `ACB_LOCK_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output wire [31:0] prdata,
	input wire [AW-1:0] sample_in,
	input wire serial_port_off_pin,
	input wire shared_powerdown_pin,
	input wire format_select_pin,
	input wire mode_pin,
	output wire conv_strobe,
	output wire ref_powered,
	output wire [DW-1:0] data_out,
	output wire [DW-1:0] data_oe_n,
	output wire over_range,
	output wire over_range_oe_n,
	output wire data_clock_out,
	output wire data_clock_oe_n,
	output wire irq
);
	localparam [AW-1:0] POS_FS = {{(AW-DW+1){1'b0}}, {(DW-1){1'b1}}};
	localparam [AW-1:0] NEG_FS = {{(AW-DW+1){1'b1}}, {(DW-1){1'b0}}};
	localparam HW = DW / 2;

	reg [31:0] ctrl_ff;
	reg [6:0] outmode_ff;
	reg [2:0] irq_ff;
	reg [2:0] mask_ff;
	reg [1:0] sync_a_ff;
	reg [1:0] sync_b_ff;
	reg [1:0] sync_c_ff;
	reg [1:0] sync_d_ff;
	reg [2:0] cnt_ff;
	reg int_clk_ff;
	reg [15:0] lock_cnt_ff;
	reg locked_ff;
	reg [3:0] cfg_ff;
	reg pd_ff;
	reg [DW:0] pipe_ff [0:`ACB_LATENCY-1];
	reg [DW-1:0] word_ff;
	reg or_ff;
	reg [DW-1:0] bus_ff;
	wire [DW-1:0] out_word;
	integer i;

	wire serial_mode;
	wire pd_pin_s;
	wire fmt_pin_s;
	wire mode_s;
	wire [1:0] mode_fn;
	wire [1:0] pwr_reg;
	wire [3:0] ratio;
	wire dcs_req;
	wire rate_ok;
	wire dcs_on;
	wire pwr_down;
	wire stby;
	wire halted;
	wire oeb_float;
	wire floating;
	wire [1:0] fmt;
	wire ilv;
	wire [2:0] nxt_cnt;
	wire [3:0] hi_len;
	wire nxt_int_clk;
	wire strobe;
	wire [3:0] nxt_cfg;
	wire wr;
	wire rd;
	wire addr_ok;
	wire [2:0] irq_set;
	wire irq_clr;

	// Two-flop synchronisers for the control pins
	// The pins are static straps or slow controls, so a level synchroniser is enough;
	// only the second stage is read, the first may go metastable.
	// After reset every pin reads low for two enabled edges, which means serial control.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_a_ff <= 2'h0;
			sync_b_ff <= 2'h0;
			sync_c_ff <= 2'h0;
			sync_d_ff <= 2'h0;
		end
		else if (clk_en)
		begin
			sync_a_ff <= {sync_a_ff[0], serial_port_off_pin};
			sync_b_ff <= {sync_b_ff[0], shared_powerdown_pin};
			sync_c_ff <= {sync_c_ff[0], format_select_pin};
			sync_d_ff <= {sync_d_ff[0], mode_pin};
		end
	end
	assign serial_mode = ~sync_a_ff[1];
	assign pd_pin_s = sync_b_ff[1];
	assign fmt_pin_s = sync_c_ff[1];
	assign mode_s = sync_d_ff[1];

	// Mode selection from pins or from registers
	assign mode_fn = outmode_ff[`ACB_OEB_MSB:`ACB_OEB_LSB];
	assign pwr_reg = ctrl_ff[`ACB_PWR_MSB:`ACB_PWR_LSB];
	assign pwr_down = serial_mode ?
		((pwr_reg == `ACB_PWR_DOWN) | ((mode_fn == `ACB_MODE_POWER_DOWN_PIN) & mode_s))
		: pd_pin_s;
	assign stby = serial_mode & ~pwr_down &
		((pwr_reg == `ACB_PWR_STANDBY) | ((mode_fn == `ACB_MODE_STBY) & mode_s));
	assign halted = pwr_down | stby;
	assign ref_powered = ~pwr_down;
	assign oeb_float = serial_mode & (mode_fn == `ACB_MODE_OEB) & mode_s;
	assign floating = halted | oeb_float;
	assign fmt = serial_mode ? ctrl_ff[`ACB_FMT_MSB:`ACB_FMT_LSB]
		: {1'b0, fmt_pin_s};
	assign ilv = ctrl_ff[`ACB_ILV_BIT];

	// Divider: field holds ratio minus one, so every code is legal
	assign ratio = {1'b0, ctrl_ff[`ACB_DIV_MSB:`ACB_DIV_LSB]} + 4'h1;
	assign dcs_req = ctrl_ff[`ACB_DCS_BIT];
	// Below the minimum rate the loop is simply left idle
	assign rate_ok = (ratio * `ACB_DCS_MIN_HZ) <= `ACB_CLK_HZ;
	assign dcs_on = dcs_req & rate_ok & locked_ff;
	assign nxt_cnt = (cnt_ff == ratio[2:0] - 3'h1) ? 3'h0 : cnt_ff + 3'h1;
	// Stabilized high time is half the period; the rising edge never moves
	assign hi_len = dcs_on ? ((ratio + 4'h1) >> 1) : 4'h1;
	// Clock level for the cycle after this edge, taken from the present count.
	// The count is zero in the strobe cycle, so the clock rises on the very edge
	// that loads a new output word: data and data clock move together.
	// With the loop off the high phase is one pclk cycle wide, whatever the ratio.
	// With the loop on and locked it is half the period, rounded up for odd ratios,
	// which is the closest a single-edge design can get to an even duty cycle.
	// Ratio 1 keeps the clock high throughout, so it has no usable low phase.
	assign nxt_int_clk = ({1'b0, cnt_ff} < hi_len);
	assign strobe = (cnt_ff == 3'h0) & ~halted & clk_en;
	assign conv_strobe = strobe;

	// Internal conversion clock, also driven out as the data clock
	// Both low power states park it low so the far side sees no stray edge.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_ff <= 3'h0;
			int_clk_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (halted)
			begin
				cnt_ff <= 3'h0; // Clock is shut down in both low power states
				int_clk_ff <= 1'b0;
			end
			else
			begin
				cnt_ff <= nxt_cnt;
				int_clk_ff <= nxt_int_clk;
			end
		end
	end

	// Lock timer restarts on any ratio or stabilizer enable change and on wake-up
	assign nxt_cfg = {ctrl_ff[`ACB_DCS_BIT], ctrl_ff[`ACB_DIV_MSB:`ACB_DIV_LSB]};
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_ff <= 4'h0;
			pd_ff <= 1'b0;
			lock_cnt_ff <= 16'h0000;
			locked_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			cfg_ff <= nxt_cfg;
			pd_ff <= halted;
			if ((nxt_cfg != cfg_ff) | halted | ~dcs_req | ~rate_ok)
			begin
				lock_cnt_ff <= 16'h0000;
				locked_ff <= 1'b0;
			end
			else if (lock_cnt_ff == LOCK_CYC[15:0] - 16'h0001)
				locked_ff <= 1'b1;
			else
				lock_cnt_ff <= lock_cnt_ff + 16'h0001;
		end
	end

	// Clamp and flag at input, then eight conversion-clock pipeline
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (i = 0; i < `ACB_LATENCY; i = i + 1)
				pipe_ff[i] <= {(DW+1){1'b0}};
		end
		else if (strobe)
		begin
			if ($signed(sample_in) > $signed(POS_FS))
				pipe_ff[0] <= {1'b1, 1'b0, {(DW-1){1'b1}}};
			else if ($signed(sample_in) < $signed(NEG_FS))
				pipe_ff[0] <= {1'b1, 1'b1, {(DW-1){1'b0}}};
			else
				pipe_ff[0] <= {1'b0, sample_in[DW-1:0]};
			for (i = 1; i < `ACB_LATENCY; i = i + 1)
				pipe_ff[i] <= pipe_ff[i-1];
		end
	end

	// Output format; pipeline carries twos complement internally
	function [DW-1:0] acb_fmt;
		input [DW-1:0] tc;
		input [1:0] sel;
		reg [DW-1:0] ob;
		begin
			ob = {~tc[DW-1], tc[DW-2:0]};
			case (sel)
				`ACB_FMT_TWOS: acb_fmt = tc;
				`ACB_FMT_GRAY: acb_fmt = ob ^ (ob >> 1);
				default: acb_fmt = ob;
			endcase
		end
	endfunction

	// Formatted word leaving the last pipeline stage
	// Formatting happens at the output so a format change needs no pipeline flush;
	// words already in flight simply come out in the new format.
	assign out_word = acb_fmt(pipe_ff[`ACB_LATENCY-1][DW-1:0], fmt);

	// Output word updates on the conversion rising edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_ff <= {DW{1'b0}};
			or_ff <= 1'b0;
		end
		else if (strobe)
		begin
			word_ff <= out_word;
			or_ff <= pipe_ff[`ACB_LATENCY-1][DW];
		end
	end

	// Bus is registered on the same edges as the data clock, so data sits on both edges
	// The phase select uses the clock level that this edge launches, never the old one,
	// otherwise the halves would swap against the clock they are meant to ride on.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bus_ff <= {DW{1'b0}};
		else if (clk_en)
		begin
			if (!ilv)
				bus_ff <= strobe ? out_word : word_ff;
			else
			begin
				bus_ff[DW-1:HW] <= {HW{1'b0}};
				for (i = 0; i < HW; i = i + 1)
				begin
					// Odd bits in the high phase, even bits in the low phase
					if (nxt_int_clk)
						bus_ff[i] <= strobe ? out_word[2*i+1] : word_ff[2*i+1];
					else
						bus_ff[i] <= word_ff[2*i];
				end
			end
		end
	end

	assign data_out = bus_ff;
	assign over_range = or_ff;
	assign data_clock_out = int_clk_ff;
	// Upper lines stay floating in interleaved mode to free them
	assign data_oe_n = floating ? {DW{1'b1}}
		: (ilv ? {{(DW-HW){1'b1}}, {HW{1'b0}}} : {DW{1'b0}});
	assign over_range_oe_n = floating;
	assign data_clock_oe_n = floating;

	// Register map, one aligned word each
	// CTRL: ratio minus one, stabilizer enable, power state, format, interleave.
	// STATUS: power-down, standby, loop locked, stabilizer active, serial mode, driving.
	// OUTMODE: seven stored bits, of which two pick the mode pin function.
	// IRQ: over-range word out, lock gained, low power entered or left; read clears.
	// MASK: same layout as IRQ; the level interrupt is their masked OR.
	// Unused bits read as zero and ignore writes.
	// In pin mode the control fields for format and power are ignored,
	// but the divider and the interleave bit still come from CTRL.
	// A CTRL write that changes the ratio or the loop enable restarts the lock timer,
	// so software must not expect a stable data clock duty cycle until it locks again.

	// APB slave: zero wait states, error on unmapped offsets
	// Read data is combinational; it is only valid in the access phase.
	assign addr_ok = (paddr == `ACB_OFF_CTRL) | (paddr == `ACB_OFF_STAT) |
		(paddr == `ACB_OFF_OUTMODE) | (paddr == `ACB_OFF_IRQ) | (paddr == `ACB_OFF_MASK);
	assign wr = psel & penable & pwrite & addr_ok;
	assign rd = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata = ~rd ? 32'h0000_0000 :
		(paddr == `ACB_OFF_CTRL) ? {23'h000000, ctrl_ff[8:0]} :
		(paddr == `ACB_OFF_STAT) ? {26'h0000000, ~floating, serial_mode,
			dcs_on, locked_ff, stby, pwr_down} :
		(paddr == `ACB_OFF_OUTMODE) ? {25'h0000000, outmode_ff} :
		(paddr == `ACB_OFF_IRQ) ? {29'h00000000, irq_ff} :
		(paddr == `ACB_OFF_MASK) ? {29'h00000000, mask_ff} : 32'h0000_0000;

	// Sticky events: a read clears, a simultaneous event still wins
	assign irq_set = {(halted != pd_ff), (locked_ff == 1'b0) & (lock_cnt_ff == LOCK_CYC[15:0] - 16'h0001)
		& ~((nxt_cfg != cfg_ff) | halted | ~dcs_req | ~rate_ok), strobe & pipe_ff[`ACB_LATENCY-1][DW]};
	assign irq_clr = rd & (paddr == `ACB_OFF_IRQ) & clk_en;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff <= `ACB_CTRL_RST;
			outmode_ff <= 7'h00;
			irq_ff <= 3'h0;
			mask_ff <= 3'h0;
		end
		else if (clk_en)
		begin
			if (wr & (paddr == `ACB_OFF_CTRL))
				ctrl_ff <= {23'h000000, pwdata[8:0]};
			if (wr & (paddr == `ACB_OFF_OUTMODE))
				outmode_ff <= pwdata[6:0];
			if (wr & (paddr == `ACB_OFF_MASK))
				mask_ff <= pwdata[2:0];
			irq_ff <= (irq_ff & {3{~irq_clr}}) | irq_set;
		end
	end
	assign irq = |(irq_ff & mask_ff);
endmodule // acb_backend

// [tb/acb_backend_props.sv]
// Port-level checker for the converter clock and output back end
`timescale 1ns/1ns
module acb_backend_props #(
	parameter DW = 16,
	parameter AW = 18
) (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire pslverr,
	input wire serial_port_off_pin,
	input wire shared_powerdown_pin,
	input wire conv_strobe,
	input wire ref_powered,
	input wire [DW-1:0] data_out,
	input wire [DW-1:0] data_oe_n,
	input wire over_range,
	input wire over_range_oe_n,
	input wire data_clock_out,
	input wire data_clock_oe_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reg [3:0] gap_ff;
	// Cycles since the last strobe; writes and floated outputs restart it, as a ratio change may
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			gap_ff <= 4'h0;
		else if (conv_strobe || data_oe_n[0] || (psel && pwrite))
			gap_ff <= 4'h0;
		else if (clk_en)
			gap_ff <= gap_ff + 4'h1;
	AST_RATIO_GAP: assert property (gap_ff < 4'h8) else $error("strobe gap too long");
	AST_FLOAT_DOWN: assert property (!ref_powered |-> &data_oe_n && data_clock_oe_n && over_range_oe_n)
		else $error("outputs driven in power-down");
	AST_PIN_DOWN: assert property ((serial_port_off_pin && shared_powerdown_pin && clk_en)[*6] |-> !ref_powered)
		else $error("pin power-down ignored");
	AST_OE_TOGETHER: assert property (data_clock_oe_n == data_oe_n[0] && over_range_oe_n == data_oe_n[0])
		else $error("data and clock enables differ");
	AST_DCO_RISE: assert property (conv_strobe && clk_en && !(psel && penable) |=> data_clock_out)
		else $error("data clock did not rise");
	AST_OVR_CLAMP: assert property (over_range && !data_oe_n[0] |-> data_out inside {16'h0000, 16'hFFFF,
		16'h8000, 16'h7FFF, 16'h00FF, 16'h0080, 16'h007F}) else $error("over-range code not clamped");
	AST_UNMAPPED: assert property (psel && penable && paddr > 8'h10 |-> pslverr) else $error("no error");
	AST_OUTMODE_MAPPED: assert property (psel && penable && paddr == 8'h08 |-> !pslverr) else $error("0x08 refused");
	// Main scenarios reached
	cover property (over_range && !data_oe_n[0]);
	cover property (!ref_powered);
	cover property (ref_powered && data_oe_n[0]);
endmodule // acb_backend_props
bind acb_backend acb_backend_props #(.DW(DW), .AW(AW)) i_acb_backend_props (.pclk, .presetn, .clk_en, .psel,
	.penable, .pwrite, .paddr, .pslverr, .serial_port_off_pin, .shared_powerdown_pin, .conv_strobe,
	.ref_powered, .data_out, .data_oe_n, .over_range, .over_range_oe_n, .data_clock_out, .data_clock_oe_n);

// [tb/acb_capture.sv]
// Far-side capture register latching the interleaved bus on both clock edges
`timescale 1ns/1ns
module acb_capture (
	input wire data_clock_out,
	input wire [7:0] data_lo,
	output reg [15:0] word_ff
);
	reg [7:0] odd_ff;
	integer i;
	// Odd bits ride the high phase; they are sampled at the rising edge itself and land in odd_ff 2 ns later
	always @(posedge data_clock_out)
		odd_ff <= #2 data_lo;
	// Even bits ride the low phase, which completes the word
	always @(negedge data_clock_out)
	begin
		#2;
		for (i = 0; i < 8; i = i + 1)
			word_ff[2*i+1 -: 2] = {odd_ff[i], data_lo[i]};
	end
endmodule // acb_capture

// [tb/adc_clock_and_output_backend_tb_top.sv]
// Self-checking bench for the converter clock and output back end
`timescale 1ns/1ns
`include "acb_defines.vh"
`define CHK(a, b) begin checks_done = checks_done + 1; if ((a) !== (b)) begin bad_count = bad_count + 1; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module adc_clock_and_output_backend_tb_top;
	reg pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, err;
	reg serial_port_off_pin = 0, shared_powerdown_pin = 0, format_select_pin = 0, mode_pin = 0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, rd;
	reg [17:0] sample_in = 18'h0;
	reg [17:0] corner [0:3] = '{18'h07FFF, 18'h08000, 18'h38000, 18'h37FFF};
	reg [17:0] h[$];
	reg [16:0] e;
	reg [1:0] fm = 0;
	reg run = 0, ilv = 0, gap_en = 0;
	integer seed = 32'h1587, bad_count = 0, checks_done = 0, p, hi, r, k, k2;
	wire pready, pslverr, conv_strobe, ref_powered, over_range, over_range_oe_n, data_clock_out, data_clock_oe_n, irq;
	wire [31:0] prdata;
	wire [15:0] data_out, data_oe_n, cap;
	acb_backend #(.LOCK_CYC(4)) i_acb_backend (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .pslverr, .prdata, .sample_in, .serial_port_off_pin, .shared_powerdown_pin,
		.format_select_pin, .mode_pin, .conv_strobe, .ref_powered, .data_out, .data_oe_n, .over_range,
		.over_range_oe_n, .data_clock_out, .data_clock_oe_n, .irq);
	acb_capture i_acb_capture (.data_clock_out(data_clock_out), .data_lo(data_out[7:0]), .word_ff(cap));
	always #5 pclk = ~pclk;
	// Random clock-enable gaps while streaming
	always @(posedge pclk)
		clk_en <= !gap_en || ($random(seed) % 4 != 0);
	function [16:0] enc(input [17:0] s, input [1:0] f);
		reg [15:0] c, ob;
		begin
			c = ($signed(s) > 32767) ? 16'h7FFF : ($signed(s) < -32768) ? 16'h8000 : s[15:0];
			ob = {~c[15], c[14:0]};
			enc[15:0] = (f == `ACB_FMT_OFFBIN) ? ob : (f == `ACB_FMT_TWOS) ? c : ob ^ (ob >> 1);
			enc[16] = ($signed(s) > 32767) || ($signed(s) < -32768);
		end
	endfunction
	// Record each sample as taken, feed a new one, check the word eight strobes later, or nine when reading the interleaved capture
	always @(posedge pclk)
		if (run && conv_strobe && clk_en)
		begin
			h.push_back(sample_in);
			k = $random(seed);
			sample_in <= (k[5:3] == 3'h0) ? corner[k[1:0]] : {{2{k[15]}}, k[15:0]};
			#1;
			if (h.size() > 8 + ilv)
			begin
				e = enc(h[h.size() - 9 - ilv], fm);
				if (!ilv)
					`CHK(({over_range, data_out}), e)
				else
					`CHK(cap, e[15:0])
			end
		end
	task apb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
		integer n;
		begin
			n = 0;
			@(posedge pclk);
			{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
			@(posedge pclk);
			penable <= 1;
			@(posedge pclk);
			while (pready !== 1'b1 && n < 100)
			begin
				n = n + 1;
				@(posedge pclk);
			end
			if (n >= 100)
				bad_count = bad_count + 1;
			q = prdata;
			err = pslverr;
			{psel, penable} <= 2'b00;
		end
	endtask
	task meas(output integer pp, output integer hh);
		begin
			pp = 0;
			hh = 0;
			@(posedge pclk);
			while (!conv_strobe && pp < 20)
			begin
				pp = pp + 1;
				@(posedge pclk);
			end
			pp = 0;
			do
			begin
				@(posedge pclk);
				pp = pp + 1;
				hh = hh + data_clock_out;
			end
			while (!conv_strobe && pp < 20);
		end
	endtask
	task stream(input [31:0] ctl, input [1:0] f, input integer n);
		begin
			apb(1, `ACB_OFF_CTRL, ctl, rd);
			h.delete();
			{fm, ilv, run, gap_en} <= {f, ctl[8], 2'b11};
			repeat (n) @(posedge pclk);
			{run, gap_en} <= 2'b00;
			$display("stream %h done", ctl);
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", checks_done, bad_count);
			if (bad_count == 0 && checks_done > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// Watchdog sized well beyond the expected run
	initial
	begin
		#400000;
		bad_count = bad_count + 1;
		tally_and_finish;
	end
	// Main sequence
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		apb(0, `ACB_OFF_CTRL, 0, rd);
		`CHK(rd, `ACB_CTRL_RST)
		apb(0, 8'h20, 0, rd);
		`CHK(({err, rd}), 33'h100000000)
		// Every ratio with the stabilizer off then on; on is the advised setting for odd ratios
		for (r = 0; r < 16; r = r + 1)
		begin
			apb(1, `ACB_OFF_CTRL, r, rd);
			repeat (30) @(posedge pclk);
			meas(p, hi);
			`CHK(p, r % 8 + 1)
			`CHK(hi, (r > 7 && r % 8 < 5) ? (r % 8 + 2) / 2 : 1)
		end
		$display("divider done");
		apb(1, `ACB_OFF_MASK, 1, rd);
		for (r = 0; r < 3; r = r + 1)
		begin
			k2 = $random(seed);
			stream(r * 64 + k2[3:0], r, 300);
		end
		stream(32'h101, 0, 300);
		stream(32'h149, 1, 300);
		apb(1, `ACB_OFF_CTRL, 32'h10, rd);
		repeat (5) @(posedge pclk);
		`CHK(({ref_powered, data_oe_n, data_clock_oe_n, over_range_oe_n}), 19'h3FFFF)
		apb(1, `ACB_OFF_MASK, 0, rd);
		#1;
		`CHK(irq, 1'b0)
		apb(1, `ACB_OFF_MASK, 1, rd);
		#1;
		`CHK(irq, 1'b1)
		apb(0, `ACB_OFF_IRQ, 0, rd);
		`CHK(rd[0], 1'b1)
		apb(0, `ACB_OFF_IRQ, 0, rd);
		`CHK(({irq, rd[0]}), 2'b00)
		apb(1, `ACB_OFF_CTRL, 32'h20, rd);
		repeat (5) @(posedge pclk);
		`CHK(({ref_powered, data_oe_n}), 17'h1FFFF)
		apb(1, `ACB_OFF_CTRL, 0, rd);
		// Each mode-pin function, pin high then low
		for (r = 1; r < 4; r = r + 1)
		begin
			apb(1, `ACB_OFF_OUTMODE, r << 5, rd);
			mode_pin <= 1;
			repeat (8) @(posedge pclk);
			`CHK(({ref_powered, data_oe_n, data_clock_oe_n}), {r != 2, 17'h1FFFF})
			mode_pin <= 0;
			repeat (8) @(posedge pclk);
			`CHK(({ref_powered, data_oe_n, data_clock_oe_n}), 18'h20000)
		end
		$display("power modes done");
		{serial_port_off_pin, shared_powerdown_pin} <= 2'b11;
		repeat (8) @(posedge pclk);
		`CHK(({ref_powered, data_oe_n}), 17'h0FFFF)
		{shared_powerdown_pin, format_select_pin} <= 2'b01;
		repeat (8) @(posedge pclk);
		stream(32'h001, 1, 200);
		format_select_pin <= 0;
		repeat (8) @(posedge pclk);
		stream(32'h041, 0, 200);
		tally_and_finish;
	end
endmodule // adc_clock_and_output_backend_tb_top
